// >>> trigger_sync_pkg.sv
// Package with constants and carrier types for the trigger and sync unit.
package trigger_sync_pkg;

  // System clock rate and derived pulse lengths.
  localparam int unsigned CLK_FREQ_HZ        = 100_000_000;
  localparam int unsigned UPDATE_PULSE_US    = 20;
  localparam int unsigned UPDATE_PULSE_CYC   = UPDATE_PULSE_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned REF_CLK_HZ         = 1_000_000;
  localparam int unsigned REF_HALF_CYC       = CLK_FREQ_HZ / (2 * REF_CLK_HZ);

  // Counter widths and the numbers of generators and boards.
  localparam int unsigned PULSE_CNT_W = 12;
  localparam int unsigned REF_CNT_W   = 6;
  localparam int unsigned WG_LEN_W    = 16;
  localparam int unsigned NUM_WG      = 4;
  localparam int unsigned NUM_BOARDS  = 2;

  // APB register byte addresses.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_WG_MODE = 8'h04;
  localparam logic [7:0] ADDR_CMD     = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_LEN_AB  = 8'h10;
  localparam logic [7:0] ADDR_LEN_CD  = 8'h14;

  // Control field positions.
  localparam int unsigned CTRL_LO_SYNC_BIT = 0;
  localparam int unsigned CTRL_HI_SYNC_BIT = 1;
  localparam int unsigned CTRL_REFCLK_BIT  = 2;

  // Command field positions (write-one pulses).
  localparam int unsigned CMD_SYNC_LO_BIT  = 0;
  localparam int unsigned CMD_SYNC_HI_BIT  = 1;
  localparam int unsigned CMD_START_LSB    = 4;
  localparam int unsigned CMD_STOP_LSB     = 8;

  // Reset values.
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [7:0]  WG_MODE_RST = 8'h00;
  localparam logic [WG_LEN_W-1:0] WG_LEN_RST = 16'h0064;

  // Generator trigger modes.
  typedef enum logic [1:0] {
    TRIG_DISABLED   = 2'h0,
    TRIG_START_ONLY = 2'h1,
    TRIG_START_STOP = 2'h2,
    TRIG_SINGLE     = 2'h3
  } trig_mode_t;

  // Per-generator run state, Gray along idle, run, step.
  typedef enum logic [1:0] {
    WG_IDLE = 2'h0,
    WG_RUN  = 2'h1,
    WG_STEP = 2'h3
  } wg_state_t;

  // APB request carrier.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// >>> trigger_sync_io.sv
// Trigger and synchronization input/output unit with APB registers.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - Board update indicator rises on update; stays high in immediate mode.
// - Generator sync output high for first half of waveform length.
// - External sync rising edge updates board only in synchronized mode.
// - Trigger rising edge starts or steps; falling edge stops when selected.
// - 1 MHz 50% reference clock output, driven only once enabled.
// - Reset switches channels off and returns outputs to zero.
// - Open inputs read low and never cause updates or triggers.
// - Generators A, B belong to lower board; C, D to higher board.
// - Four generators, each with own trigger and sync output.
// - Synchronized mode: indicator low, one 20 us pulse per sync event.
// - Immediate mode passes values straight through, ignoring sync input.
// - Sync events come from input edge, remote command or host button.
// - Trigger modes: disabled, start-only, start-stop, single-step.
module trigger_sync_io (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lower_board_update_input,
  input  wire logic        higher_board_update_input,
  input  wire logic [3:0]  wavegen_trigger_input,
  output logic             lower_board_update_indicator,
  output logic             higher_board_update_indicator,
  output logic [3:0]       wavegen_sync_output,
  output logic             reference_clock_output,
  output logic [1:0]       board_update_strobe,
  output logic [3:0]       wavegen_step_strobe,
  output logic [3:0]       wavegen_running,
  output logic             channels_off
);

  localparam int unsigned PW = trigger_sync_pkg::PULSE_CNT_W;
  localparam int unsigned LW = trigger_sync_pkg::WG_LEN_W;

  // Bundle the APB request.
  trigger_sync_pkg::apb_req_t req;
  assign req = '{psel, penable, pwrite, paddr, pwdata};

  // Two-stage synchronizers; the first stage feeds only the second.
  logic [5:0] meta_ff, sync_ff, prev_ff;
  logic [5:0] nxt_meta, nxt_sync, nxt_prev, rise, fall;
  always_comb begin
    nxt_meta = {wavegen_trigger_input, higher_board_update_input, lower_board_update_input};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
      prev_ff <= 6'h00;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

  // APB register state.
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [7:0]  mode_ff, nxt_mode;
  logic [LW-1:0] len_ff [4];
  logic [LW-1:0] nxt_len [4];
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0] cmd_ff, nxt_cmd;
  logic [3:0]  wavegen_running_ff;
  logic        access;
  assign access = req.psel & req.penable & ~pready_ff;

  // Register decode; one wait state so pready is a flop.
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_mode    = mode_ff;
    nxt_len     = len_ff;
    nxt_cmd     = 32'h0000_0000;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (access) begin
      nxt_pready = 1'b1;
      nxt_prdata = 32'h0000_0000;
      case (req.paddr)
        trigger_sync_pkg::ADDR_CTRL: begin
          if (req.pwrite) nxt_ctrl = {29'h0, req.pwdata[2:0]};
          nxt_prdata = ctrl_ff;
        end
        trigger_sync_pkg::ADDR_WG_MODE: begin
          if (req.pwrite) nxt_mode = req.pwdata[7:0];
          nxt_prdata = {24'h0, mode_ff};
        end
        trigger_sync_pkg::ADDR_CMD: begin
          if (req.pwrite) nxt_cmd = req.pwdata;
        end
        trigger_sync_pkg::ADDR_STATUS: begin
          nxt_prdata = {22'h0, sync_ff, wavegen_running_ff};
        end
        trigger_sync_pkg::ADDR_LEN_AB: begin
          if (req.pwrite) begin
            nxt_len[0] = req.pwdata[15:0];
            nxt_len[1] = req.pwdata[31:16];
          end
          nxt_prdata = {len_ff[1], len_ff[0]};
        end
        trigger_sync_pkg::ADDR_LEN_CD: begin
          if (req.pwrite) begin
            nxt_len[2] = req.pwdata[15:0];
            nxt_len[3] = req.pwdata[31:16];
          end
          nxt_prdata = {len_ff[3], len_ff[2]};
        end
        default: nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_ff    <= trigger_sync_pkg::CTRL_RST;
      mode_ff    <= trigger_sync_pkg::WG_MODE_RST;
      for (int i = 0; i < 4; i++) len_ff[i] <= trigger_sync_pkg::WG_LEN_RST;
      cmd_ff     <= 32'h0000_0000;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      mode_ff    <= nxt_mode;
      len_ff     <= nxt_len;
      cmd_ff     <= nxt_cmd;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  // Per-board sync logic: lower board is index 0, higher board index 1.
  logic [1:0]    ind_ff, nxt_ind, upd_ff, nxt_upd;
  logic [PW-1:0] pcnt_ff [2];
  logic [PW-1:0] nxt_pcnt [2];
  logic [1:0]    sync_mode, sync_evt;
  logic [PW-1:0] ind_run_ff, nxt_ind_run;
  assign sync_mode = {ctrl_ff[trigger_sync_pkg::CTRL_HI_SYNC_BIT],
                      ctrl_ff[trigger_sync_pkg::CTRL_LO_SYNC_BIT]};
  assign sync_evt  = rise[1:0] | {cmd_ff[trigger_sync_pkg::CMD_SYNC_HI_BIT],
                                  cmd_ff[trigger_sync_pkg::CMD_SYNC_LO_BIT]};
  // A new event during a pulse restarts it; the update strobe fires per event.
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      nxt_upd[b]  = 1'b0;
      nxt_ind[b]  = 1'b0;
      nxt_pcnt[b] = pcnt_ff[b];
      if (!sync_mode[b]) begin
        nxt_ind[b]  = 1'b1;
        nxt_pcnt[b] = '0;
        nxt_upd[b]  = 1'b1;
      end else if (sync_evt[b]) begin
        nxt_upd[b]  = 1'b1;
        nxt_ind[b]  = 1'b1;
        nxt_pcnt[b] = PW'(trigger_sync_pkg::UPDATE_PULSE_CYC - 1);
      end else if (pcnt_ff[b] != '0) begin
        nxt_ind[b]  = 1'b1;
        nxt_pcnt[b] = pcnt_ff[b] - PW'(1);
      end
    end
    nxt_ind_run = sync_evt[0] ? PW'(1) : (ind_ff[0] ? ind_run_ff + PW'(1) : '0); // Check aid.
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ind_ff     <= 2'h0;
      upd_ff     <= 2'h0;
      pcnt_ff    <= '{default: '0};
      ind_run_ff <= '0;
    end else begin
      ind_ff     <= nxt_ind;
      upd_ff     <= nxt_upd;
      pcnt_ff    <= nxt_pcnt;
      ind_run_ff <= nxt_ind_run;
    end
  end
  assign lower_board_update_indicator  = ind_ff[0];
  assign higher_board_update_indicator = ind_ff[1];
  assign board_update_strobe           = upd_ff;
  // Waveform generators; 0,1 on lower board, 2,3 on higher board.
  trigger_sync_pkg::wg_state_t wst_ff [4];
  trigger_sync_pkg::wg_state_t nxt_wst [4];
  logic [LW-1:0] pos_ff [4];
  logic [LW-1:0] nxt_pos [4];
  logic [3:0]    wsync_ff, nxt_wsync, step_ff, nxt_step, nxt_running;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_wg
      trigger_sync_pkg::trig_mode_t md;
      logic start, stop, adv;
      assign md = trigger_sync_pkg::trig_mode_t'(mode_ff[2*g +: 2]);
      always_comb begin
        start = cmd_ff[trigger_sync_pkg::CMD_START_LSB + g];
        stop  = cmd_ff[trigger_sync_pkg::CMD_STOP_LSB + g];
        case (md)
          trigger_sync_pkg::TRIG_START_ONLY: start = start | rise[2+g];
          trigger_sync_pkg::TRIG_START_STOP: begin
            start = start | rise[2+g];
            stop  = stop | fall[2+g];
          end
          default: ;
        endcase
        nxt_wst[g] = wst_ff[g];
        nxt_pos[g] = pos_ff[g];
        adv = 1'b0;
        case (wst_ff[g])
          trigger_sync_pkg::WG_IDLE: begin
            if (md == trigger_sync_pkg::TRIG_SINGLE) begin
              nxt_wst[g] = trigger_sync_pkg::WG_STEP;
            end else if (start) begin
              nxt_wst[g] = trigger_sync_pkg::WG_RUN;
              nxt_pos[g] = '0;
              adv        = 1'b1;
            end
          end
          trigger_sync_pkg::WG_RUN: begin
            adv        = 1'b1;
            nxt_pos[g] = (pos_ff[g] + LW'(1) >= len_ff[g]) ? '0 : pos_ff[g] + LW'(1);
          end
          trigger_sync_pkg::WG_STEP: begin
            if (md != trigger_sync_pkg::TRIG_SINGLE) begin
              nxt_wst[g] = trigger_sync_pkg::WG_IDLE;
            end else if (rise[2+g]) begin
              adv        = 1'b1;
              nxt_pos[g] = (pos_ff[g] + LW'(1) >= len_ff[g]) ? '0 : pos_ff[g] + LW'(1);
            end
          end
          default: nxt_wst[g] = trigger_sync_pkg::WG_IDLE;
        endcase
        if (stop || md == trigger_sync_pkg::TRIG_DISABLED && !start &&
            wst_ff[g] == trigger_sync_pkg::WG_STEP) begin
          nxt_wst[g] = trigger_sync_pkg::WG_IDLE;
          adv        = 1'b0;
          nxt_pos[g] = '0;
        end
        nxt_step[g]    = adv;
        nxt_running[g] = nxt_wst[g] != trigger_sync_pkg::WG_IDLE;
        // Sync is high over the first half of the memory; low when stopped.
        nxt_wsync[g] = nxt_running[g] && (nxt_pos[g] < (len_ff[g] >> 1));
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wst_ff             <= '{default: trigger_sync_pkg::WG_IDLE};
      pos_ff             <= '{default: '0};
      wsync_ff           <= 4'h0;
      step_ff            <= 4'h0;
      wavegen_running_ff <= 4'h0;
    end else begin
      wst_ff             <= nxt_wst;
      pos_ff             <= nxt_pos;
      wsync_ff           <= nxt_wsync;
      step_ff            <= nxt_step;
      wavegen_running_ff <= nxt_running;
    end
  end
  assign wavegen_sync_output = wsync_ff;
  assign wavegen_step_strobe = step_ff;
  assign wavegen_running     = wavegen_running_ff;
  // Reference clock divider; held low until enabled.
  logic [5:0] rcnt_ff, nxt_rcnt;
  logic       rclk_ff, nxt_rclk, off_ff, nxt_off;
  always_comb begin
    nxt_rcnt = rcnt_ff;
    nxt_rclk = rclk_ff;
    if (!ctrl_ff[trigger_sync_pkg::CTRL_REFCLK_BIT]) begin
      nxt_rcnt = '0;
      nxt_rclk = 1'b0;
    end else if (rcnt_ff == 6'(trigger_sync_pkg::REF_HALF_CYC - 1)) begin
      nxt_rcnt = '0;
      nxt_rclk = ~rclk_ff;
    end else begin
      nxt_rcnt = rcnt_ff + 6'h01;
    end
    nxt_off = 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rcnt_ff <= 6'h00;
      rclk_ff <= 1'b0;
      off_ff  <= 1'b1;
    end else begin
      rcnt_ff <= nxt_rcnt;
      rclk_ff <= nxt_rclk;
      off_ff  <= nxt_off;
    end
  end
  assign reference_clock_output = rclk_ff;
  assign channels_off           = off_ff;
  // Checks on the main behaviour; the pulse check counts in helper logic, not a long delay.
  a_ind_immediate: assert property (@(posedge ref_clk) disable iff (srst)
    !sync_mode[0] |=> lower_board_update_indicator) else $error("indicator low");
  a_pulse_len: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(lower_board_update_indicator) && sync_mode[0] && $past(sync_mode[0], 2)
    |-> $past(ind_run_ff) == PW'(trigger_sync_pkg::UPDATE_PULSE_CYC))
    else $error("pulse length wrong");
  a_sync_update: assert property (@(posedge ref_clk) disable iff (srst)
    sync_mode[0] && rise[0] |=> board_update_strobe[0]) else $error("no update");
  a_no_evt_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    sync_mode[0] && !sync_evt[0] && pcnt_ff[0] == '0 |=> !lower_board_update_indicator)
    else $error("stray pulse");
  a_refclk_off: assert property (@(posedge ref_clk) disable iff (srst)
    !ctrl_ff[2] |=> !reference_clock_output) else $error("refclk active");
  a_refclk_half: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_ff[2] && $rose(reference_clock_output) |=> reference_clock_output[*8] ##42
    !reference_clock_output) else $error("refclk period");
  a_wg_start: assert property (@(posedge ref_clk) disable iff (srst)
    mode_ff[1:0] == 2'h1 && rise[2] && cmd_ff[8] == 1'b0 |=> wavegen_running[0])
    else $error("gen not started");
  a_wg_stop_low: assert property (@(posedge ref_clk) disable iff (srst)
    !wavegen_running[0] |-> !wavegen_sync_output[0]) else $error("sync high idle");
  a_sync_chain: assert property (@(posedge ref_clk) disable iff (srst)
    rise[0] && !$past(srst, 3) |-> $past(lower_board_update_input, 2) &&
    !$past(lower_board_update_input, 3)) else $error("sync path");
  c_ext_sync: cover property (@(posedge ref_clk) sync_mode[0] && rise[0]);
  c_wg_run: cover property (@(posedge ref_clk) $rose(wavegen_running[1]));
  c_step: cover property (@(posedge ref_clk) wst_ff[3] == trigger_sync_pkg::WG_STEP && rise[5]);
endmodule

// >>> lab_edge_source.sv
// Model of the laboratory equipment that drives the trigger and sync pins.
`timescale 1ns/1ps
module lab_edge_source (
  input  wire logic       ref_clk,
  output logic [5:0]      pins
);
  // Pins rest low, as the pull-downs hold an open input low.
  initial begin
    pins = 6'h00;
  end

  // One source per pin; a pulse and the low gap after it last two cycles or more.
  task pulse(input int idx, input int cyc);
    @(posedge ref_clk);
    pins[idx] <= 1'b1;
    repeat ((cyc < 2) ? 2 : cyc) @(posedge ref_clk);
    pins[idx] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// >>> trigger_sync_io_tb_top.sv
// Self-checking testbench for the trigger and sync unit.
`timescale 1ns/1ps
module trigger_sync_io_tb_top;
  logic                       ref_clk;
  logic                       srst;
  trigger_sync_pkg::apb_req_t req;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  wire  [5:0]                 pins;
  logic                       lo_ind;
  logic                       hi_ind;
  logic [3:0]                 wg_sync;
  logic                       ref_out;
  logic [1:0]                 upd_stb;
  logic [3:0]                 step_stb;
  logic [3:0]                 running;
  logic                       chan_off;
  wire  [16:0]                obs;
  logic [31:0]                q;
  logic [31:0]                len;
  logic [31:0]                stb;
  logic                       e;
  logic [15:0]                seed;
  int                         w;
  int                         la;
  int                         num_errors;
  int                         comparisons;

  // Observed outputs: 0 lower, 1 higher, 2-5 sync, 6 ref, 7-10 run, 11-14 step, 15-16 update.
  assign obs = {upd_stb, step_stb, running, ref_out, wg_sync, hi_ind, lo_ind};

  // Trigger pins A, B sit with the lower board, C, D with the higher one.
  trigger_sync_io DUT (
    .ref_clk                       (ref_clk),
    .srst                          (srst),
    .psel                          (req.psel),
    .penable                       (req.penable),
    .pwrite                        (req.pwrite),
    .paddr                         (req.paddr),
    .pwdata                        (req.pwdata),
    .prdata                        (prdata),
    .pready                        (pready),
    .pslverr                       (pslverr),
    .lower_board_update_input      (pins[0]),
    .higher_board_update_input     (pins[1]),
    .wavegen_trigger_input         (pins[5:2]),
    .lower_board_update_indicator  (lo_ind),
    .higher_board_update_indicator (hi_ind),
    .wavegen_sync_output           (wg_sync),
    .reference_clock_output        (ref_out),
    .board_update_strobe           (upd_stb),
    .wavegen_step_strobe           (step_stb),
    .wavegen_running               (running),
    .channels_off                  (chan_off)
  );

  lab_edge_source src (
    .ref_clk (ref_clk),
    .pins    (pins)
  );

  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Fibonacci-style shift register for repeatable random values.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // A generator stepping every cycle keeps its sync high for half its length.
  function automatic logic [31:0] half_len(input int l);
    return 32'(l / 2);
  endfunction

  task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic check_bit(input string nm, input logic ex, input logic got);
    comparisons++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s expected %b seen %b", nm, ex, got);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
  endtask

  // Waits up to lim cycles for a high run on one output, then returns its length.
  task automatic measure(input int idx, input int lim, output logic [31:0] l);
    int n;
    n = 0;
    l = 32'h0;
    while (obs[idx] !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    while (obs[idx] === 1'b1 && l < lim) begin
      @(posedge ref_clk);
      l++;
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog sized well above the expected run of some five thousand cycles.
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end

  initial begin
    num_errors = 0;
    comparisons = 0;
    seed = 16'h3817;
    srst = 1'b1;
    req = '0;
    repeat (16) @(posedge ref_clk);
    check_bit("channels_off", 1'b1, chan_off);
    check_val("sync outputs", 32'h0, {28'h0, wg_sync});
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check_bit("channels_off", 1'b0, chan_off);
    measure(6, 200, len);
    check_val("idle reference clock", 32'h0, len);
    apb(1'b0, trigger_sync_pkg::ADDR_LEN_AB, 32'h0);
    check_val("length reset", 32'h0064_0064, q);
    apb(1'b0, 8'h30, 32'h0);
    check_bit("unmapped error", 1'b1, e);
    // Immediate mode keeps the indicator high and ignores the pin.
    fork
      src.pulse(0, 5);
      measure(0, 100, len);
    join
    check_val("immediate indicator", 32'h64, len);
    check_bit("immediate strobe", 1'b1, upd_stb[0]);
    apb(1'b1, trigger_sync_pkg::ADDR_CTRL, 32'h3);
    repeat (4) @(posedge ref_clk);
    measure(0, 100, len);
    check_val("resting indicator", 32'h0, len);
    seed = lfsr(seed);
    w = 2 + int'(seed[2:0]);
    fork
      src.pulse(0, w);
      measure(0, 3000, len);
      measure(15, 50, q);
    join
    check_val("sync pulse width", 32'(trigger_sync_pkg::UPDATE_PULSE_CYC), len);
    check_val("update strobe", 32'h1, q);
    fork
      apb(1'b1, trigger_sync_pkg::ADDR_CMD, 32'h2);
      measure(1, 3000, len);
      measure(16, 50, stb);
    join
    check_val("command pulse width", 32'(trigger_sync_pkg::UPDATE_PULSE_CYC), len);
    check_val("higher update strobe", 32'h1, stb);
    apb(1'b1, trigger_sync_pkg::ADDR_CTRL, 32'h7);
    measure(6, 300, len);
    check_val("reference half period", 32'(trigger_sync_pkg::REF_HALF_CYC), len);
    // Modes A start-only, B start-stop, C disabled, D single-step.
    seed = lfsr(seed);
    la = 4 + 2 * int'(seed[6:3]);
    apb(1'b1, trigger_sync_pkg::ADDR_LEN_AB, {16'h0010, 16'(la)});
    apb(1'b1, trigger_sync_pkg::ADDR_WG_MODE, 32'hC9);
    fork
      src.pulse(2, w);
      measure(2, 300, len);
    join
    check_val("generator sync high", half_len(la), len);
    check_bit("start-only running", 1'b1, running[0]);
    apb(1'b1, trigger_sync_pkg::ADDR_CMD, 32'h100);
    repeat (3) @(posedge ref_clk);
    check_bit("stopped running", 1'b0, running[0]);
    check_bit("stopped sync", 1'b0, wg_sync[0]);
    fork
      src.pulse(3, 40);
      measure(8, 200, len);
    join
    check_val("start-stop run", 32'h28, len);
    fork
      src.pulse(4, w);
      measure(9, 100, len);
    join
    check_val("disabled run", 32'h0, len);
    repeat (3) begin
      fork
        src.pulse(5, w);
        measure(14, 50, len);
      join
      check_val("single step", 32'h1, len);
    end
    // A second reset in mid-run returns every setting to its reset value.
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check_bit("channels_off", 1'b1, chan_off);
    srst <= 1'b0;
    apb(1'b0, trigger_sync_pkg::ADDR_CTRL, 32'h0);
    check_val("control after reset", 32'h0, q);
    check_bit("indicator after reset", 1'b1, lo_ind);
    test_done();
  end
endmodule
